// ### reset_ctrl_pkg.sv
// Constants shared by the reset control unit.
package reset_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  // Register byte addresses in the special function register space.
  localparam logic [ADDR_W-1:0] CAUSE_ADDR  = 12'hfcc;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 12'hfde;
  localparam logic [ADDR_W-1:0] KEY_ADDR    = 12'hfdf;
  // Key codes written to the key register.
  localparam logic [DATA_W-1:0] KEY_EXT_ENABLE = 8'hb2;
  localparam logic [DATA_W-1:0] KEY_AREA_VECT  = 8'hd4;
  localparam logic [DATA_W-1:0] KEY_FLAG_CLEAR = 8'h71;
  // Field positions.
  localparam int CFG_EXT_DIS_BIT = 0;
  localparam int CFG_W           = 3;
  localparam int FLAG_CLEAR_BIT  = 7;
  localparam int CAUSE_W         = 7;
  localparam int WDOG_BIT        = 0;
  localparam int CLKF_BIT        = 1;
  localparam int VD1_BIT         = 2;
  localparam int VD2_BIT         = 3;
  localparam int TRIMR_BIT       = 4;
  localparam int TRIMS_BIT       = 5;
  localparam int FLASH_BIT       = 6;
  // Values after reset.
  localparam logic [CFG_W-1:0]   CFG_RESET   = 3'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 7'h00;
  localparam logic [DATA_W-1:0]  READ_IDLE   = 8'h00;
  // Execution starts from the vector held at this address pair.
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
  // Clock rate and default warm-up length in high-frequency clock cycles.
  localparam int CLK_MHZ         = 125;
  localparam int WARMUP_CYCLES   = 2048;
  localparam int TRIM_LOAD_CYCLE = 16;
  localparam int WARM_W          = 16;
  // Sequencer states.
  typedef enum logic [1:0] {ST_RESET, ST_WARMUP, ST_RUN} seq_state_t;
endpackage

// ### reset_control_unit.sv
// Reset control unit: source gathering, keyed config, cause flags, warm-up.
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
// How it works
// [RULE1] Eight sources (power-on, pin and six internal) merge into one system reset.
// [RULE2] Config bit 0 chooses whether the external pin may reset.
// [RULE3] Applied pin-enable value resets only on power-on, survives other resets.
// [RULE4] Raw config value returns to zero on every reset.
// [RULE5] Writing key 0xb2 copies the raw pin-enable bit into the applied copy.
// [RULE6] Key 0xd4 applies config bits 1 and 2, 0x71 clears; others ignored.
// [RULE7] Software never reads or read-modify-writes the key register.
// [RULE8] Software writes keys only in normal mode with gear clock at quarter rate.
// [RULE9] Reads at the key address return the applied settings, pin bit 0.
// [RULE10] Config bits 7 to 3 always read as zero.
// [RULE11] Cause register holds one sticky flag per internal reset source.
// [RULE12] Cause bit 5 reads 1 after abnormal trimming data is seen.
// [RULE13] Cause flags clear only by power-on, pin reset or keyed clear.
// [RULE14] Key 0x71 after clear bit written 1 zeroes flags and clear bit.
// [RULE15] Cause bit 7 is write-only and reads zero.
// [RULE16] While any source is active, counter, CPU and peripherals stay reset.
// [RULE17] After release the warm-up counter times the wait before CPU runs.
// [RULE18] Trimming data is loaded during warm-up.
// [RULE19] CPU starts from the vector at 0xfffe to 0xffff.
// [RULE20] A reset during warm-up restarts the counter from zero.
// [RULE21] Every source gives the same reset, except register initialisation.
// [RULE22] Power-on and pin reset are ORed.
// [RULE23] Applied value zero lets the pin reset, one blocks it.
// [RULE24] Cause flags are caught before the shared reset clears other state.
module reset_control_unit #(
  parameter int WARMUP_LEN = reset_ctrl_pkg::WARMUP_CYCLES,
  parameter int TRIM_W     = 8
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic                              ext_reset_n,
  input  wire logic                              voltage_detect1_req,
  input  wire logic                              voltage_detect2_req,
  input  wire logic                              watchdog_req,
  input  wire logic                              clock_fault_req,
  input  wire logic                              trim_fault_req,
  input  wire logic                              flash_standby_req,
  input  wire logic                              trim_abnormal,
  input  wire logic [TRIM_W-1:0]                 trim_data,
  input  wire logic [reset_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [reset_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [reset_ctrl_pkg::DATA_W-1:0] reg_rdata,
  output logic                                   system_reset,
  output logic                                   warmup_busy,
  output logic                                   cpu_run,
  output logic      [15:0]                       cpu_vector_addr,
  output logic      [TRIM_W-1:0]                 trim_ref
);
  import reset_ctrl_pkg::*;

  logic                  pin_meta;
  logic                  pin_sync_n;
  logic                  ext_active;
  logic                  internal_active;
  logic                  any_reset;
  logic [CFG_W-1:0]      cfg_raw;
  logic [CFG_W-1:0]      cfg_applied;
  logic                  clear_pending;
  logic [CAUSE_W-1:0]    cause_flags;
  logic [CAUSE_W-1:0]    cause_set;
  logic                  key_wr;
  logic                  flag_wipe;
  logic [WARM_W-1:0]     warm_cnt;
  seq_state_t            state;

  // The pin is asynchronous to the core clock, so it passes two stages.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta   <= 1'b1;
      pin_sync_n <= 1'b1;
    end else begin
      pin_meta   <= ext_reset_n;
      pin_sync_n <= pin_meta;
    end
  end

  // A blocked pin is ignored entirely; power-on stays able to reset.
  assign ext_active = ~pin_sync_n & ~cfg_applied[CFG_EXT_DIS_BIT]; // [RULE23] [RULE2]

  // Internal sources; the trim status flag alone causes no reset.
  assign internal_active = voltage_detect1_req | voltage_detect2_req |
                           watchdog_req | clock_fault_req |
                           trim_fault_req | flash_standby_req;

  // One shared reset from all eight sources.
  assign any_reset = rst | ext_active | internal_active; // [RULE1] [RULE22] [RULE21]

  // Key writes are dropped while any reset is active, so a code written in
  // the last reset cycle cannot slip into the applied copies.
  assign key_wr = reg_wr & (reg_addr == KEY_ADDR) & ~any_reset;

  // Keyed clear fires only when the clear bit was armed beforehand.
  assign flag_wipe = key_wr & (reg_wdata == KEY_FLAG_CLEAR) & clear_pending;

  // Raw config bits; lost on every reset so software must rewrite them.
  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      cfg_raw <= CFG_RESET; // [RULE4]
    end else if (reg_wr && reg_addr == CONFIG_ADDR) begin
      cfg_raw <= reg_wdata[CFG_W-1:0];
    end
  end

  // Applied copies only move on the matching key, so a stray write to the
  // config register can never lock out the reset pin by itself.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_applied <= CFG_RESET; // [RULE3]
    end else if (key_wr) begin
      case (reg_wdata)
        KEY_EXT_ENABLE: begin
          cfg_applied[CFG_EXT_DIS_BIT] <= cfg_raw[CFG_EXT_DIS_BIT]; // [RULE5]
        end
        KEY_AREA_VECT: begin
          cfg_applied[2:1] <= cfg_raw[2:1]; // [RULE6]
        end
        default: begin
          cfg_applied <= cfg_applied;
        end
      endcase
    end
  end

  // Flag-clear request bit; reset by any reset and by its own key.
  always_ff @(posedge ref_clk) begin
    if (any_reset || flag_wipe) begin
      clear_pending <= 1'b0; // [RULE14]
    end else if (reg_wr && reg_addr == CAUSE_ADDR) begin
      clear_pending <= reg_wdata[FLAG_CLEAR_BIT];
    end
  end

  // Set sources lined up with their flag positions.
  assign cause_set = {flash_standby_req, trim_abnormal, trim_fault_req,
                      voltage_detect2_req, voltage_detect1_req,
                      clock_fault_req, watchdog_req}; // [RULE11] [RULE12]

  // Sticky cause flags. They are not touched by internal resets, and a
  // source seen in a clearing cycle still sets its flag.
  genvar gi;
  generate
    for (gi = 0; gi < CAUSE_W; gi++) begin : g_flag
      always_ff @(posedge ref_clk) begin
        if (cause_set[gi]) begin
          cause_flags[gi] <= 1'b1; // [RULE24]
        end else if (rst || ext_active || flag_wipe) begin
          cause_flags[gi] <= 1'b0; // [RULE13]
        end
      end
    end
  endgenerate

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= READ_IDLE;
    end else begin
      case (reg_addr)
        CAUSE_ADDR: begin
          reg_rdata <= {1'b0, cause_flags}; // [RULE15]
        end
        CONFIG_ADDR: begin
          reg_rdata <= {5'h00, cfg_raw}; // [RULE10]
        end
        KEY_ADDR: begin
          reg_rdata <= {5'h00, cfg_applied}; // [RULE9]
        end
        default: begin
          reg_rdata <= READ_IDLE;
        end
      endcase
    end
  end

  // Sequencer: reset hold, warm-up count, then run.
  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      state    <= ST_RESET; // [RULE16]
      warm_cnt <= '0; // [RULE20]
    end else begin
      case (state)
        ST_RESET: begin
          state    <= ST_WARMUP;
          warm_cnt <= '0;
        end
        ST_WARMUP: begin
          if (warm_cnt == WARM_W'(WARMUP_LEN - 1)) begin
            state <= ST_RUN;
          end else begin
            warm_cnt <= warm_cnt + 1'b1; // [RULE17]
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  // Outputs to core and peripherals, all registered.
  always_ff @(posedge ref_clk) begin
    if (any_reset) begin
      system_reset <= 1'b1; // [RULE16]
      warmup_busy  <= 1'b0;
      cpu_run      <= 1'b0;
    end else begin
      system_reset <= (state == ST_RESET);
      warmup_busy  <= (state != ST_RUN);
      cpu_run      <= (state == ST_RUN);
    end
  end

  // The core fetches its start address through this pair.
  always_ff @(posedge ref_clk) begin
    cpu_vector_addr <= RESET_VECTOR_ADDR; // [RULE19]
  end

  // Trim references are taken early in warm-up so comparators settle
  // before the CPU starts; a fresh reset simply reloads them.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trim_ref <= '0;
    end else if (state == ST_WARMUP &&
                 warm_cnt == WARM_W'(TRIM_LOAD_CYCLE)) begin
      trim_ref <= trim_data; // [RULE18]
    end
  end

  // All checks run on the core clock. Power-on reset masks them, since it
  // forces every register to its reset value anyway, except a cause flag whose source is active.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_por_clears_enable: assert property ( // [RULE3]
    $past(rst) |-> cfg_applied == CFG_RESET)
    else $error("Applied setting not cleared by power-on.");

  a_key_applies_pin: assert property ( // [RULE5]
    key_wr && reg_wdata == KEY_EXT_ENABLE |=>
      cfg_applied[0] == $past(cfg_raw[0]))
    else $error("Key did not apply the pin setting.");

  a_bad_key_ignored: assert property ( // [RULE6]
    key_wr && reg_wdata != KEY_EXT_ENABLE && reg_wdata != KEY_AREA_VECT
      |=> $stable(cfg_applied))
    else $error("Unknown key changed applied settings.");

  a_flags_survive: assert property ( // [RULE13]
    cause_flags != CAUSE_RESET && !ext_active && !flag_wipe
      |=> cause_flags != CAUSE_RESET)
    else $error("Cause flags lost without a clearing event.");

  a_keyed_clear: assert property ( // [RULE14]
    flag_wipe && cause_set == CAUSE_RESET |=>
      cause_flags == CAUSE_RESET && !clear_pending)
    else $error("Keyed clear did not empty the flags.");

  a_hold_in_reset: assert property ( // [RULE16]
    any_reset |=> system_reset && !cpu_run ##1 !cpu_run)
    else $error("CPU ran while a reset was active.");

  a_warmup_length: assert property ( // [RULE17]
    $rose(cpu_run) |-> $past(warm_cnt, 2) == WARM_W'(WARMUP_LEN - 1))
    else $error("Warm-up ended at the wrong count.");

  a_warmup_restart: assert property ( // [RULE20]
    any_reset |=> warm_cnt == '0 && state == ST_RESET)
    else $error("Reset did not restart the warm-up.");

  a_config_high_zero: assert property ( // [RULE10]
    reg_rd && reg_addr == CONFIG_ADDR |=> reg_rdata[7:3] == 5'h00)
    else $error("Config upper bits read nonzero.");

  // Register side, cause flags and the pin path. Internal resets must leave
  // the applied settings and the earlier flags alone.
  a_raw_cleared: assert property ( // [RULE4]
    any_reset |=> cfg_raw == CFG_RESET)
    else $error("Raw config survived a reset.");

  a_applied_kept: assert property ( // [RULE3]
    any_reset |=> $stable(cfg_applied))
    else $error("Applied settings moved during a reset.");

  a_status_bit: assert property ( // [RULE9]
    reg_rd && reg_addr == KEY_ADDR |=>
      reg_rdata[CFG_EXT_DIS_BIT] == $past(cfg_applied[CFG_EXT_DIS_BIT]))
    else $error("Status read does not show the applied pin setting.");

  a_cause_top_zero: assert property ( // [RULE15]
    reg_rd && reg_addr == CAUSE_ADDR |=> !reg_rdata[FLAG_CLEAR_BIT])
    else $error("Flag-clear bit read back as one.");

  a_sources_flagged: assert property ( // [RULE11] [RULE12]
    cause_set != CAUSE_RESET |=>
      (cause_flags & $past(cause_set)) == $past(cause_set))
    else $error("A reset source did not set its cause flag.");

  a_flags_kept: assert property ( // [RULE24]
    internal_active && !ext_active |=>
      (cause_flags & $past(cause_flags)) == $past(cause_flags))
    else $error("Internal reset disturbed earlier cause flags.");

  a_pin_clears_flags: assert property ( // [RULE13]
    ext_active && cause_set == CAUSE_RESET |=> cause_flags == CAUSE_RESET)
    else $error("Pin reset left cause flags set.");

  a_clear_self: assert property ( // [RULE14]
    flag_wipe |=> !clear_pending)
    else $error("Flag-clear bit did not clear itself.");

  a_pin_resets: assert property ( // [RULE22]
    !pin_sync_n && !cfg_applied[CFG_EXT_DIS_BIT] |=>
      system_reset && !cpu_run)
    else $error("Enabled pin did not reset the device.");

  a_blocked_pin: assert property ( // [RULE23]
    cfg_applied[CFG_EXT_DIS_BIT] && !internal_active && state == ST_RUN
      |=> cpu_run)
    else $error("Blocked pin still stopped the CPU.");

  a_trim_capture: assert property ( // [RULE18]
    state == ST_WARMUP && warm_cnt == WARM_W'(TRIM_LOAD_CYCLE) |=>
      trim_ref == $past(trim_data))
    else $error("Trim data not taken during warm-up.");

  a_vector_fixed: assert property ( // [RULE19]
    cpu_run |-> cpu_vector_addr == RESET_VECTOR_ADDR)
    else $error("Start vector address is wrong.");

  // Main scenarios that the bench should reach.
  c_pin_blocked: cover property (
    !pin_sync_n && cfg_applied[0] && cpu_run);
  c_warmup_done: cover property ($rose(cpu_run));
  c_keyed_clear: cover property (flag_wipe);
  c_reset_in_warmup: cover property (warmup_busy && internal_active);
  c_pin_reset: cover property (ext_active && cause_flags != CAUSE_RESET);

endmodule // reset_control_unit

// ### reset_source_model.sv
// Model of the reset sources and trim storage around the reset unit.
`timescale 1ns/100ps
module reset_source_model (
  input  wire logic       ref_clk,
  input  wire logic       fire,
  input  wire logic [2:0] which,
  output logic            ext_reset_n,
  output logic [5:0]      req,
  output logic            trim_bad,
  output logic [7:0]      trim_data
);
  logic [2:0] hold = 3'h0;
  logic [2:0] sel  = 3'h0;
  logic [7:0] pat  = 8'h00;
  // A source stays asserted four cycles, long enough for the pin sync.
  always_ff @(posedge ref_clk) begin
    pat <= pat + 8'h01;
    if (fire) begin
      hold <= 3'h4;
      sel  <= which;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  // Index 0 to 5 are the internal sources, 6 bad trim data, 7 the pin.
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      req[k] = (hold != 3'h0) && (sel == 3'(k));
    end
  end
  assign trim_bad    = (hold != 3'h0) && (sel == 3'h6);
  assign ext_reset_n = !((hold != 3'h0) && (sel == 3'h7));
  // Storage output changes every cycle so a stale capture cannot hide.
  assign trim_data   = pat;
endmodule // reset_source_model

// ### tb_top.sv
// Self-checking bench for the reset control unit.
`timescale 1ns/100ps
module tb_top;
  import reset_ctrl_pkg::*;
  localparam int WL = 32;
  logic ref_clk = 1'b0, rst = 1'b1, fire = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0, ext_reset_n, trim_bad, system_reset;
  logic warmup_busy, cpu_run;
  logic [2:0]        which = 3'h0;
  logic [5:0]        req;
  logic [7:0]        trim_data, trim_ref;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic [15:0]       cpu_vector_addr;
  logic [7:0]        flags;
  logic [2:0]        phase;
  int n_fail = 0, checks = 0, cycles = 0, b;
  // Reset, warm-up and run flags seen as one value.
  assign phase = {system_reset, warmup_busy, cpu_run};
  always #4 ref_clk = ~ref_clk;
  reset_source_model src (.ref_clk(ref_clk), .fire(fire), .which(which),
    .ext_reset_n(ext_reset_n), .req(req), .trim_bad(trim_bad),
    .trim_data(trim_data));
  reset_control_unit #(.WARMUP_LEN(WL), .TRIM_W(8)) uut (
    .ref_clk(ref_clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .voltage_detect1_req(req[2]), .voltage_detect2_req(req[3]),
    .watchdog_req(req[0]), .clock_fault_req(req[1]),
    .trim_fault_req(req[4]), .flash_standby_req(req[5]),
    .trim_abnormal(trim_bad), .trim_data(trim_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .system_reset(system_reset),
    .warmup_busy(warmup_busy), .cpu_run(cpu_run),
    .cpu_vector_addr(cpu_vector_addr), .trim_ref(trim_ref));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits sample one step after the edge, once registered outputs settle.
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp,
                       input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    check(what, 16'(exp), 16'(reg_rdata));
  endtask
  task automatic pulse(input logic [2:0] w);
    @(posedge ref_clk);
    fire  <= 1'b1;
    which <= w;
    @(posedge ref_clk);
    fire  <= 1'b0;
  endtask
  // Follows one reset to the end of warm-up and times the warm-up.
  task automatic wait_run();
    int n;
    logic [7:0] tr;
    #1;
    n = 0;
    while (system_reset !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    check("held", 16'h4, 16'(phase));
    n = 0;
    while (system_reset !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    // The trim source counts up each cycle, so its capture is predictable.
    tr = trim_data + 8'(TRIM_LOAD_CYCLE - 1);
    check("warming", 16'h2, 16'(phase));
    n = 0;
    while (cpu_run !== 1'b1 && n < WL + 10) begin
      tick();
      n++;
    end
    check("warmup", 16'(WL), 16'(n));
    check("running", 16'h1, 16'(phase));
    check("trim", 16'(tr), 16'(trim_ref));
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    wait_run();
    rdchk(CAUSE_ADDR, 8'h00, "cause");
    rdchk(CONFIG_ADDR, 8'h00, "config");
    rdchk(KEY_ADDR, 8'h00, "status");
    rdchk(12'h000, 8'h00, "unmapped");
    check("vector", 16'hfffe, cpu_vector_addr);
    $display("test reset values done");
    // Only bit 0 goes live on the first code; bits 1 and 2 need the second.
    wr(CONFIG_ADDR, 8'hff);
    rdchk(CONFIG_ADDR, 8'h07, "config");
    wr(KEY_ADDR, 8'h5a);
    rdchk(KEY_ADDR, 8'h00, "status");
    wr(KEY_ADDR, KEY_EXT_ENABLE);
    rdchk(KEY_ADDR, 8'h01, "status");
    wr(KEY_ADDR, KEY_AREA_VECT);
    rdchk(KEY_ADDR, 8'h07, "status");
    pulse(3'h7);
    repeat (12) tick();
    check("pin blocked", 16'h1, 16'(phase));
    $display("test keyed config done");
    flags = 8'h00;
    for (int i = 0; i < 7; i++) begin
      b = (i == 5) ? 6 : (i == 6) ? 5 : i;
      flags[b] = 1'b1;
      pulse(3'(i));
      if (i < 6) begin
        wait_run();
        rdchk(CONFIG_ADDR, 8'h00, "config");
        rdchk(KEY_ADDR, 8'h07, "status");
      end else begin
        repeat (8) tick();
      end
      rdchk(CAUSE_ADDR, flags, "cause");
    end
    $display("test cause flags done");
    wr(KEY_ADDR, KEY_FLAG_CLEAR);
    rdchk(CAUSE_ADDR, 8'h7f, "cause");
    wr(CAUSE_ADDR, 8'h80);
    rdchk(CAUSE_ADDR, 8'h7f, "cause");
    wr(KEY_ADDR, KEY_FLAG_CLEAR);
    rdchk(CAUSE_ADDR, 8'h00, "cause");
    $display("test flag clear done");
    // A second reset in mid warm-up must start the count over.
    pulse(3'h1);
    repeat (12) tick();
    check("mid warmup", 16'h2, 16'(phase));
    pulse(3'h1);
    wait_run();
    // The clear bit cleared itself, so a bare key must leave the flag.
    wr(KEY_ADDR, KEY_FLAG_CLEAR);
    rdchk(CAUSE_ADDR, 8'h02, "cause");
    $display("test warmup restart done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    wait_run();
    rdchk(KEY_ADDR, 8'h00, "status");
    rdchk(CAUSE_ADDR, 8'h00, "cause");
    pulse(3'h0);
    wait_run();
    rdchk(CAUSE_ADDR, 8'h01, "cause");
    pulse(3'h7);
    wait_run();
    rdchk(CAUSE_ADDR, 8'h00, "cause");
    $display("test power-on and pin done");
    conclude();
  end
endmodule // tb_top
